// [design/ivs_pkg.sv]
// Purpose: constants and carrier types for the interrupt vector selector
// Assumes: 24-bit program addresses, 62-entry vector tables
// Notes:   vector location = table base + 2 * vector number
package ivs_pkg;

  // ---------------------------------------------------------------------
  // table layout
  // ---------------------------------------------------------------------
  localparam int          NUM_VECT      = 62;
  localparam int          NUM_TRAP      = 8;
  localparam int          NUM_IRQ       = 54;
  localparam int          FIRST_IRQ     = 8;
  localparam int          FIRST_RSVD    = 53;
  localparam int          ADDR_W        = 24;
  localparam logic [23:0] PRI_BASE      = 24'h000004;
  localparam logic [23:0] ALT_OFFSET    = 24'h000080;
  localparam logic [23:0] RESET_ADDR    = 24'h000000;
  localparam int          ALT_SEL_BIT   = 15;

  // ---------------------------------------------------------------------
  // trap numbers
  // ---------------------------------------------------------------------
  localparam logic [5:0]  TRAP_OSC      = 6'h01;
  localparam logic [5:0]  TRAP_ADDR     = 6'h02;
  localparam logic [5:0]  TRAP_STACK    = 6'h03;
  localparam logic [5:0]  TRAP_MATH     = 6'h04;
  localparam logic [3:0]  TRAP_BASE_LVL = 4'h8;

  localparam logic [15:0] CTRL2_RESET   = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic [5:0]  num;
    logic [3:0]  level;
    logic [23:0] loc;
  } ivs_vec_t;

endpackage : ivs_pkg

// [design/ivs_top.sv]
// Purpose: merge trap and interrupt requests into one core request and
//          give the program-memory location of the winning vector
// Assumes: requests and priorities come from logic on clk_i
// Notes:   one-cycle pipeline from request to outputs
`timescale 1ns/1ps
module ivs_top
  import ivs_pkg::*;
(
  input  wire logic                clk_i,            // core clock 20 MHz
  input  wire logic                sys_rst_i,        // async reset, high
  input  wire logic [NUM_IRQ-1:0]  irq_req_i,        // interrupt requests
  input  wire logic [3*NUM_IRQ-1:0] irq_prio_i,      // 3-bit level each
  input  wire logic [3:0]          trap_req_i,       // osc,addr,stack,math
  input  wire logic [3:0]          cpu_priority_level_i, // current level
  input  wire logic [15:0]         interrupt_control_two_i, // control reg
  output logic                     core_req_o,       // merged request
  output logic [5:0]               vec_num_o,        // winning number
  output logic [3:0]               vec_level_o,      // winning level
  output logic [ADDR_W-1:0]        vec_loc_o,        // vector location
  output logic [ADDR_W-1:0]        reset_pc_o        // reset start address
);

  // ---------------------------------------------------------------------
  // interrupt arbitration
  // ---------------------------------------------------------------------
  // level 0 never exceeds any cpu level, so it acts as disabled
  logic [NUM_IRQ-1:0] irq_live;
  logic [2:0]         irq_lvl [NUM_IRQ];

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_src
      assign irq_lvl[g]  = irq_prio_i[3*g +: 3];
      // reserved entries carry no source
      assign irq_live[g] = irq_req_i[g] &&
                           (g + FIRST_IRQ < FIRST_RSVD) &&
                           (irq_lvl[g] != 3'h0);
    end
  endgenerate

  // scan from highest number down so the lowest number wins ties
  logic [2:0] best_lvl;
  logic [5:0] best_idx;
  logic       best_any;
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 6'h00;
    best_any = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_live[i] && (irq_lvl[i] >= best_lvl)) begin
        best_lvl = irq_lvl[i];
        best_idx = 6'(i);
        best_any = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // trap arbitration
  // ---------------------------------------------------------------------
  // fixed trap levels: oscillator 14, address 13, stack 12, math 11
  // traps sit on levels 11..14 that no interrupt can reach, so a trap
  // above the cpu level always beats every interrupt
  wire       trap_any = |trap_req_i;
  wire [5:0] trap_num = trap_req_i[0] ? TRAP_OSC   :
                        trap_req_i[1] ? TRAP_ADDR  :
                        trap_req_i[2] ? TRAP_STACK : TRAP_MATH;
  wire [3:0] trap_lvl = TRAP_BASE_LVL + 4'(7 - trap_num);

  // ---------------------------------------------------------------------
  // winner selection and location
  // ---------------------------------------------------------------------
  wire [3:0] irq_lvl4  = {1'b0, best_lvl};
  wire       use_trap  = trap_any &&
                         (trap_lvl > cpu_priority_level_i);
  wire       use_irq   = best_any &&
                         (irq_lvl4 > cpu_priority_level_i);
  wire       win_any   = use_trap || use_irq;
  wire [5:0] irq_num   = 6'(best_idx + 6'(FIRST_IRQ));
  wire [5:0] win_num   = use_trap ? trap_num : irq_num;
  wire [3:0] win_lvl   = use_trap ? trap_lvl : irq_lvl4;
  wire       alt_table_select =
                         interrupt_control_two_i[ALT_SEL_BIT];
  // alternate table sits 0x80 above the primary one, same layout
  wire [ADDR_W-1:0] alt_base = PRI_BASE + ALT_OFFSET;
  wire [ADDR_W-1:0] base_loc = alt_table_select ?
                               alt_base : PRI_BASE;
  // each entry is two addresses wide, so the number is doubled
  wire [ADDR_W-1:0] win_loc  = base_loc +
                               {17'h00000, win_num, 1'b0};

  ivs_vec_t out_d;
  ivs_vec_t out_q;
  assign out_d = '{valid: win_any, num: win_num,
                   level: win_lvl, loc: win_loc};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  // registers are cleared on reset, so the core starts from address zero
  logic [ADDR_W-1:0] reset_pc_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reset_pc_q <= RESET_ADDR;
    end else begin
      reset_pc_q <= RESET_ADDR;
    end
  end

  assign core_req_o  = out_q.valid;
  assign vec_num_o   = out_q.num;
  assign vec_level_o = out_q.level;
  assign vec_loc_o   = out_q.loc;
  assign reset_pc_o  = reset_pc_q;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  // one clock domain here, so the properties share clock and reset
  default clocking cb_asrt @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_win;
    win_any;
  endsequence
  sequence s_req_next;
    ##1 core_req_o;
  endsequence
  sequence s_trap_win;
    use_trap;
  endsequence
  sequence s_irq_win;
    use_irq && !use_trap;
  endsequence

  a_merge_req: assert property (
    s_win |-> s_req_next)
    else $error("merged request missing");
  a_no_req_idle: assert property (
    !win_any |=> !core_req_o)
    else $error("request without a winner");
  a_loc_formula: assert property (
    core_req_o |-> vec_loc_o == PRI_BASE +
      ($past(alt_table_select) ? ALT_OFFSET : 24'h000000) +
      {17'h00000, vec_num_o, 1'b0})
    else $error("vector location wrong");

  a_alt_select: assert property (
    (win_any && alt_table_select) |=> vec_loc_o >= 24'h000084)
    else $error("alternate table not used");
  a_pri_select: assert property (
    (win_any && !alt_table_select) |=> vec_loc_o < 24'h000084 &&
      vec_loc_o >= PRI_BASE)
    else $error("primary table range wrong");
  a_level_above: assert property (
    core_req_o |-> vec_level_o > $past(cpu_priority_level_i))
    else $error("winner not above cpu level");

  a_trap_first: assert property (
    s_trap_win |=> vec_num_o < 6'h08)
    else $error("trap did not win");
  a_trap_level: assert property (
    s_trap_win |=> vec_level_o == 4'hF - vec_num_o[3:0])
    else $error("trap level wrong");
  a_trap_order: assert property (
    (use_trap && trap_req_i[0]) |=> vec_num_o == TRAP_OSC)
    else $error("oscillator trap lost");

  a_irq_levels: assert property (
    s_irq_win |=> vec_level_o inside {[4'h1:4'h7]})
    else $error("interrupt level out of range");
  a_irq_number: assert property (
    s_irq_win |=> vec_num_o >= 6'(FIRST_IRQ))
    else $error("interrupt took a trap number");
  a_irq_range: assert property (
    (core_req_o && vec_num_o >= 6'h08) |-> vec_num_o < 6'(FIRST_RSVD))
    else $error("reserved vector selected");

  a_tie_low: assert property (
    (!trap_any && irq_live[0] && irq_lvl[0] == 3'h7 &&
     cpu_priority_level_i < 4'h7) |=> vec_num_o == 6'h08)
    else $error("lower number lost a tie");

  // every live source either loses to a higher level or, on its own
  // level, to a lower number only
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_tie
      a_tie_order: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (use_irq && !use_trap && irq_live[g]) |=>
        (vec_level_o > {1'b0, $past(irq_lvl[g])}) ||
        (vec_level_o == {1'b0, $past(irq_lvl[g])} &&
         vec_num_o <= 6'(g + FIRST_IRQ)))
        else $error("fixed order within a level broken");
    end
  endgenerate

  a_reset_pc: assert property (
    reset_pc_o == RESET_ADDR)
    else $error("reset address not zero");

endmodule : ivs_top

// [bench/ivs_core_model.sv]
// Purpose: program-memory side of the core exception sequencer
// Assumes: word index = vector location / 2, tables below 0x000100
// Notes:   unused slots hold a default handler that resets the device
`timescale 1ns/1ps
module ivs_core_model
  import ivs_pkg::*;
(
  input  wire logic [ADDR_W-1:0] loc_i,   // vector location asked for
  output logic      [ADDR_W-1:0] fetch_o  // handler address read back
);
  logic [ADDR_W-1:0] mem [0:127];

  initial begin
    for (int w = 0; w < 128; w++) mem[w] = 24'h000FFC;
    for (int n = 1; n < 53; n++)
      if (n < 5 || n > 7) begin
        mem[2 + n]  = 24'h001000 + 24'(n * 4);
        mem[66 + n] = mem[2 + n];
      end
  end

  // above 0x0000FF nothing answers, so show a value that cannot match
  assign fetch_o = (loc_i[23:8] == 16'h0000) ? mem[loc_i[7:1]] : ~loc_i;
endmodule : ivs_core_model

// [bench/tb_interrupt_vector_selector.sv]
// Purpose: self-checking bench for the interrupt vector selector
// Assumes: one-cycle latency, inputs driven on the falling edge
// Notes:   corner cases first, then random traffic and a mid-run reset
`timescale 1ns/1ps
module tb_interrupt_vector_selector;
  import ivs_pkg::*;
  logic                 clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic [NUM_IRQ-1:0]   irq_req_i = '0;
  logic [3*NUM_IRQ-1:0] irq_prio_i = '0;
  logic [3:0]           trap_req_i = '0;
  logic [3:0]           cpu_priority_level_i = '0;
  logic [15:0]          interrupt_control_two_i = '0;
  logic                 core_req_o;
  logic [5:0]           vec_num_o;
  logic [3:0]           vec_level_o;
  logic [23:0]          vec_loc_o, reset_pc_o, fetch_o;
  logic [31:0]          seed = 32'h13D00477;
  ivs_vec_t             exp_q = '0;
  int                   mismatches = 0, n_compared = 0, cycles = 0;

  ivs_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .irq_req_i(irq_req_i),
    .irq_prio_i(irq_prio_i), .trap_req_i(trap_req_i),
    .cpu_priority_level_i(cpu_priority_level_i),
    .interrupt_control_two_i(interrupt_control_two_i),
    .core_req_o(core_req_o), .vec_num_o(vec_num_o),
    .vec_level_o(vec_level_o), .vec_loc_o(vec_loc_o),
    .reset_pc_o(reset_pc_o));
  ivs_core_model u_mem (.loc_i(vec_loc_o), .fetch_o(fetch_o));

  initial forever #25 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  // traps are scanned high to low so the lowest number is kept last
  function automatic ivs_vec_t predict();
    ivs_vec_t r;
    logic [2:0] p;
    r = '0;
    for (int t = 3; t >= 0; t--)
      if (trap_req_i[t] && 4'(14 - t) > cpu_priority_level_i) begin
        r = '{1'b1, 6'(t + 1), 4'(14 - t), 24'h0};
      end
    for (int k = 44; k >= 0 && !(r.valid && r.num < 8); k--) begin
      p = irq_prio_i[3*k +: 3];
      if (irq_req_i[k] && {1'b0, p} > cpu_priority_level_i && p != 3'h0
          && (!r.valid || {1'b0, p} >= r.level))
        r = '{1'b1, 6'(k + 8), {1'b0, p}, 24'h0};
    end
    r.loc = PRI_BASE + {r.num, 1'b0}
          + (interrupt_control_two_i[15] ? ALT_OFFSET : 24'h0);
    return r;
  endfunction : predict

  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic apply(input logic [53:0] rq, input logic [161:0] pr,
                       input logic [3:0] tr, input logic [3:0] cpu,
                       input logic [15:0] ctl);
    @(negedge clk_i);
    chk(24'(core_req_o), 24'(exp_q.valid));
    chk(reset_pc_o, RESET_ADDR);
    if (exp_q.valid) begin
      chk(24'(vec_num_o), 24'(exp_q.num));
      chk(24'(vec_level_o), 24'(exp_q.level));
      chk(vec_loc_o, exp_q.loc);
      chk(fetch_o, 24'h001000 + {exp_q.num, 2'b00});
    end
    {irq_req_i, irq_prio_i, trap_req_i} = {rq, pr, tr};
    {cpu_priority_level_i, interrupt_control_two_i} = {cpu, ctl};
    exp_q = predict();
  endtask : apply

  task automatic summarize();
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    logic [191:0] pr;
    logic [63:0]  q;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    apply(54'h1, 162'h5, 4'h0, 4'h0, 16'h0000);
    apply(54'h1, 162'h5, 4'h0, 4'h0, 16'h8000);
    apply(54'h9, 162'h3 | (162'h3 << 9), 4'h0, 4'h2, 16'h0000);
    apply(54'h1 << 45, 162'h7 << 135, 4'h0, 4'h0, 16'h0000);
    apply(54'h1, 162'h7, 4'h0, 4'h7, 16'h0000);
    apply(54'h1, 162'h7, 4'hF, 4'h0, 16'h8000);
    apply(54'h1, 162'h7, 4'h8, 4'hB, 16'h0000);
    apply(54'h1, 162'h7, 4'h8, 4'hA, 16'h0000);
    for (int i = 0; i < 460; i++) begin
      for (int j = 0; j < 6; j++) pr[32*j +: 32] = rnd();
      q = {rnd(), rnd()};
      apply(q[53:0], pr[161:0], q[57:54] & q[61:58],
            {q[63] & q[62], q[61:59]}, {q[58], q[14:0]});
      if (i == 400) begin
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        chk(24'(core_req_o), 24'h0);
        chk(vec_loc_o, 24'h0);
        sys_rst_i = 1'b0;
        // inputs still stand, so the first edge after release follows them
        exp_q = predict();
      end
    end
    apply(54'h0, 162'h0, 4'h0, 4'h0, 16'h0000);
    summarize();
  end
endmodule : tb_interrupt_vector_selector
